// File: hw/cmm_params.svh
// Constants of the code memory mapping block: offsets, fields, resets, timing.
// Assumes inclusion by the top module only.
`ifndef CMM_PARAMS_SVH
`define CMM_PARAMS_SVH

// ----------------------------------------
// Register indices (byte address = 4 x index)
// ----------------------------------------
`define CMM_AUX1_INDEX 8'ha2
`define CMM_CODE_RAM_CONFIG_INDEX 8'hd1
`define CMM_STAT_INDEX 8'h40

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define CMM_DPS_BIT 0
`define CMM_ZERO_BIT 2
`define CMM_GF_BIT 3
`define CMM_BOOT_ROM_ENABLE_BIT 5
`define CMM_RPS_BIT 3
`define CMM_AUX1_RESET 8'h20
`define CMM_CODE_RAM_CONFIG_RESET 8'h00
`define CMM_ST_STRAP_BIT 0
`define CMM_ST_EA_BIT 1
`define CMM_ST_NV_BIT 2
`define CMM_ST_LPC_BIT 3
`define CMM_ST_LOAD_BIT 4
`define CMM_ST_FAULT_BIT 5

// ----------------------------------------
// Program and data space
// ----------------------------------------
`define CMM_BOOT_VECTOR 16'hf800
`define CMM_COLD_VECTOR 16'h0000
`define CMM_CFG_AREA_BASE 16'h7f00
`define CMM_CFG_AREA_BYTES 256

// ----------------------------------------
// Timing
// ----------------------------------------
`define CMM_CLK_HZ 25000000
`define CMM_NV_LOAD_MS 1500
`define CMM_SYNC_FILL 2'h2
`define CMM_EXT_WAIT 2'h2

`endif

// File: hw/cmm_pkg.sv
// Types of the code memory mapping block.
// Assumes the constants header sits beside it.
`default_nettype none

package cmm_pkg;
  // ----------------------------------------
  // Enumerations
  // ----------------------------------------
  typedef enum logic [1:0] {
    FS_CODE_RAM,
    FS_BOOT_ROM,
    FS_EXTERNAL,
    FS_BLOCKED
  } cmm_fetch_src_type;

  typedef enum logic [1:0] {
    XT_EXPANDED,
    XT_CODE_RAM,
    XT_EXTERNAL
  } cmm_xdata_tgt_type;

  typedef enum logic [2:0] {
    EXT_IDLE,
    EXT_ADDR,
    EXT_STROBE,
    EXT_WAIT,
    EXT_DONE
  } cmm_ext_state_type;
endpackage : cmm_pkg

`default_nettype wire

// File: hw/cmm_sync.sv
// Two-stage synchroniser for pin inputs, any width.
// Assumes pins are sampled on pclk with no relation to it.
`default_nettype none

module cmm_sync #(
  parameter int WIDTH = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] pin_async,
  output logic [WIDTH-1:0] pin_sync_q
);
  // ----------------------------------------
  // Stages
  // ----------------------------------------
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      pin_sync_q <= '0;
    end else begin
      meta_q <= pin_async;
      pin_sync_q <= meta_q;
    end
  end
endmodule : cmm_sync

`default_nettype wire

// File: hw/cmm_code_map.sv
// Program and data memory mapping: decodes fetches and data moves onto memories.
// Assumes one core request of each kind per cycle and an APB master for registers.
//
// Design decision made here: the APB slave port.
`default_nettype none
`include "cmm_params.svh"

module cmm_code_map
  import cmm_pkg::*;
#(
  parameter int unsigned NV_LOAD_CYCLES = `CMM_NV_LOAD_MS * (`CMM_CLK_HZ / 1000)
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata_q,
  output logic pready_q,
  output logic pslverr_q,
  input wire logic fetch_req,
  input wire logic [15:0] fetch_addr,
  input wire logic pmove_req,
  input wire logic [15:0] pmove_addr,
  input wire logic xdata_req,
  input wire logic xdata_write,
  input wire logic [15:0] xdata_addr,
  input wire logic [7:0] xdata_wdata,
  input wire logic external_data_select,
  input wire logic external_access_pin,
  input wire logic boot_select_pin,
  input wire logic low_pin_count_strap,
  input wire logic [7:0] port0_in,
  output var cmm_fetch_src_type fetch_source_q,
  output logic rom_en_q,
  output logic [14:0] rom_addr_q,
  output logic code_ram_en_q,
  output logic code_ram_we_q,
  output logic [14:0] code_ram_addr_q,
  output logic [7:0] code_ram_wdata_q,
  output var cmm_xdata_tgt_type xdata_target_q,
  output logic expanded_data_ram_en_q,
  output logic ext_data_en_q,
  output logic xdata_we_q,
  output logic [15:0] xdata_addr_q,
  output logic program_store_strobe_n_q,
  output logic [7:0] port0_out_q,
  output logic port0_oe_n_q,
  output logic [7:0] port2_out_q,
  output logic [7:0] ext_fetch_data_q,
  output logic ext_fetch_valid_q,
  output logic data_pointer_select_q,
  output logic [15:0] reset_vector_q,
  output logic boot_from_nonvolatile_q,
  output logic boot_load_done_q
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [10:0] pins_q;
  logic [7:0] p0_sync;
  logic ea_sync, bsel_sync, lpc_sync;

  cmm_sync #(.WIDTH(11)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_async({port0_in, external_access_pin, boot_select_pin, low_pin_count_strap}),
    .pin_sync_q(pins_q)
  );
  assign {p0_sync, ea_sync, bsel_sync, lpc_sync} = pins_q;

  // ----------------------------------------
  // Straps caught once after reset release
  // ----------------------------------------
  logic [1:0] strap_cnt_q;
  logic strap_done_q, ea_q, lpc_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_cnt_q <= 2'h0;
      strap_done_q <= 1'b0;
      ea_q <= 1'b0;
      lpc_q <= 1'b0;
      boot_from_nonvolatile_q <= 1'b0;
      reset_vector_q <= `CMM_COLD_VECTOR;
    end else if (!strap_done_q) begin
      // Wait for the synchronisers to fill before trusting the pins
      if (strap_cnt_q != `CMM_SYNC_FILL) begin
        strap_cnt_q <= strap_cnt_q + 2'h1;
      end else begin
        strap_done_q <= 1'b1;
        ea_q <= ea_sync;
        lpc_q <= lpc_sync;
        boot_from_nonvolatile_q <= bsel_sync;
        reset_vector_q <= ea_sync ? `CMM_BOOT_VECTOR : `CMM_COLD_VECTOR;
      end
    end
    // Pin ignored once caught, so the port is free afterwards
  end

  // ----------------------------------------
  // Nonvolatile load timer
  // ----------------------------------------
  logic [25:0] load_cnt_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_cnt_q <= 26'h0;
      boot_load_done_q <= 1'b0;
    end else if (strap_done_q && !boot_load_done_q) begin
      // Host tool source has no fixed duration, so done at once
      if (!boot_from_nonvolatile_q || load_cnt_q == 26'(NV_LOAD_CYCLES - 1)) begin
        boot_load_done_q <= 1'b1;
      end else begin
        load_cnt_q <= load_cnt_q + 26'h1;
      end
    end
  end

  // ----------------------------------------
  // APB slave and registers
  // ----------------------------------------
  logic gf_q, boot_rom_enable_q, rps_q, fault_q, fault_set;
  logic setup, access, hit_aux1, hit_code_ram_config, hit_stat;
  logic [7:0] aux1_rd, code_ram_config_rd, stat_rd;

  assign setup = psel && !penable;
  assign access = psel && penable && pready_q;
  assign hit_aux1 = paddr == {2'h0, `CMM_AUX1_INDEX, 2'h0};
  assign hit_code_ram_config = paddr == {2'h0, `CMM_CODE_RAM_CONFIG_INDEX, 2'h0};
  assign hit_stat = paddr == {2'h0, `CMM_STAT_INDEX, 2'h0};
  // Reserved bits read as zero
  assign aux1_rd = {2'h0, boot_rom_enable_q, 1'b0, gf_q, 1'b0, 1'b0, data_pointer_select_q};
  assign code_ram_config_rd = {4'h0, rps_q, 3'h0};
  assign stat_rd = {2'h0, fault_q, boot_load_done_q, lpc_q,
                    boot_from_nonvolatile_q, ea_q, strap_done_q};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      // No wait state: answer is registered at setup, ready in the first access cycle
      pready_q <= setup;
      if (setup) begin
        pslverr_q <= !(hit_aux1 || hit_code_ram_config || hit_stat);
        prdata_q <= {24'h0, hit_aux1 ? aux1_rd : hit_code_ram_config ? code_ram_config_rd :
                     hit_stat ? stat_rd : 8'h0};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_pointer_select_q <= 1'(`CMM_AUX1_RESET >> `CMM_DPS_BIT);
      gf_q <= 1'b0;
      boot_rom_enable_q <= 1'b1;
    end else if (access && pwrite && hit_aux1) begin
      data_pointer_select_q <= pwdata[`CMM_DPS_BIT];
      gf_q <= pwdata[`CMM_GF_BIT];
      boot_rom_enable_q <= pwdata[`CMM_BOOT_ROM_ENABLE_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rps_q <= 1'(`CMM_CODE_RAM_CONFIG_RESET >> `CMM_RPS_BIT);
    end else if (access && pwrite && hit_code_ram_config) begin
      rps_q <= pwdata[`CMM_RPS_BIT];
    end
  end

  // Sticky fault, write one to clear; a new fault in the same cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_q <= 1'b0;
    end else if (fault_set) begin
      fault_q <= 1'b1;
    end else if (access && pwrite && hit_stat && pwdata[`CMM_ST_FAULT_BIT]) begin
      fault_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Program space decode
  // ----------------------------------------
  logic f_hi, m_hi, ext_idle;
  cmm_ext_state_type ext_st_q;

  assign f_hi = fetch_addr[15];
  assign m_hi = pmove_addr[15];
  assign ext_idle = ext_st_q == EXT_IDLE;
  assign fault_set = ((fetch_req && f_hi) || (pmove_req && m_hi)) && !boot_rom_enable_q && lpc_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fetch_source_q <= FS_BOOT_ROM;
    end else if (fetch_req) begin
      if (!f_hi) fetch_source_q <= FS_CODE_RAM;
      else if (boot_rom_enable_q) fetch_source_q <= FS_BOOT_ROM;
      else if (lpc_q) fetch_source_q <= FS_BLOCKED;
      else fetch_source_q <= FS_EXTERNAL;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rom_en_q <= 1'b0;
      rom_addr_q <= 15'h0;
    end else begin
      rom_en_q <= 1'b0;
      if (fetch_req && f_hi && boot_rom_enable_q) begin
        rom_en_q <= 1'b1;
        rom_addr_q <= fetch_addr[14:0];
      end else if (pmove_req && m_hi && boot_rom_enable_q) begin
        rom_en_q <= 1'b1;
        rom_addr_q <= pmove_addr[14:0];
      end
    end
  end

  // Single code RAM port; fetch first, then program move, then data move.
  // No stall is given: writes come from boot ROM code
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code_ram_en_q <= 1'b0;
      code_ram_we_q <= 1'b0;
      code_ram_addr_q <= 15'h0;
      code_ram_wdata_q <= 8'h0;
    end else begin
      code_ram_en_q <= 1'b0;
      code_ram_we_q <= 1'b0;
      if (fetch_req && !f_hi) begin
        code_ram_en_q <= 1'b1;
        code_ram_addr_q <= fetch_addr[14:0];
      end else if (pmove_req && !m_hi) begin
        code_ram_en_q <= 1'b1;
        code_ram_addr_q <= pmove_addr[14:0];
      end else if (xdata_req && rps_q) begin
        code_ram_en_q <= 1'b1;
        code_ram_we_q <= xdata_write;
        code_ram_addr_q <= xdata_addr[14:0];
        code_ram_wdata_q <= xdata_wdata;
      end
    end
  end

  // ----------------------------------------
  // Data move decode
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xdata_target_q <= XT_EXPANDED;
      expanded_data_ram_en_q <= 1'b0;
      ext_data_en_q <= 1'b0;
      xdata_we_q <= 1'b0;
      xdata_addr_q <= 16'h0;
    end else begin
      expanded_data_ram_en_q <= 1'b0;
      ext_data_en_q <= 1'b0;
      xdata_we_q <= 1'b0;
      if (xdata_req) begin
        xdata_we_q <= xdata_write;
        xdata_addr_q <= xdata_addr;
        if (rps_q) begin
          xdata_target_q <= XT_CODE_RAM;
        end else if (external_data_select) begin
          xdata_target_q <= XT_EXTERNAL;
          ext_data_en_q <= 1'b1;
        end else begin
          xdata_target_q <= XT_EXPANDED;
          expanded_data_ram_en_q <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // External program bus
  // ----------------------------------------
  logic [1:0] wait_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_st_q <= EXT_IDLE;
      wait_q <= 2'h0;
      program_store_strobe_n_q <= 1'b1;
      port0_out_q <= 8'h0;
      port0_oe_n_q <= 1'b1;
      port2_out_q <= 8'h0;
      ext_fetch_data_q <= 8'h0;
      ext_fetch_valid_q <= 1'b0;
    end else begin
      ext_fetch_valid_q <= 1'b0;
      case (ext_st_q)
        EXT_IDLE: begin
          // Never leaves idle on a low pin count part
          if (fetch_req && f_hi && !boot_rom_enable_q && !lpc_q) begin
            ext_st_q <= EXT_ADDR;
            {port2_out_q, port0_out_q} <= fetch_addr;
            port0_oe_n_q <= 1'b0;
          end else if (pmove_req && m_hi && !boot_rom_enable_q && !lpc_q) begin
            ext_st_q <= EXT_ADDR;
            {port2_out_q, port0_out_q} <= pmove_addr;
            port0_oe_n_q <= 1'b0;
          end
        end
        EXT_ADDR: begin
          ext_st_q <= EXT_STROBE;
          program_store_strobe_n_q <= 1'b0;
          port0_oe_n_q <= 1'b1;
          wait_q <= 2'h0;
        end
        EXT_STROBE: begin
          // Memory data passes the pin synchroniser before it is taken
          if (wait_q == `CMM_EXT_WAIT) begin
            ext_st_q <= EXT_DONE;
          end else begin
            wait_q <= wait_q + 2'h1;
          end
        end
        EXT_DONE: begin
          ext_fetch_data_q <= p0_sync;
          ext_fetch_valid_q <= 1'b1;
          program_store_strobe_n_q <= 1'b1;
          ext_st_q <= EXT_IDLE;
        end
        default: begin
          ext_st_q <= EXT_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_dps_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
    access && pwrite && hit_aux1 |=> data_pointer_select_q == $past(pwdata[0]))
    else $error("data pointer select did not follow write");
  chk_reserved_read_zero: assert property (@(posedge pclk) disable iff (!presetn)
    access && !pwrite && (hit_aux1 || hit_code_ram_config) |-> prdata_q[7:6] == 2'h0
      && prdata_q[2] == 1'b0)
    else $error("reserved bits read nonzero");
  chk_map_bit_priority: assert property (@(posedge pclk) disable iff (!presetn)
    xdata_req && rps_q && !(fetch_req && !f_hi) && !(pmove_req && !m_hi)
      |=> xdata_target_q == XT_CODE_RAM && code_ram_en_q && !ext_data_en_q
      && code_ram_we_q == $past(xdata_write) && code_ram_addr_q == $past(xdata_addr[14:0]))
    else $error("code RAM mapping not honoured");
  chk_external_data_select_target: assert property (@(posedge pclk) disable iff (!presetn)
    xdata_req && !rps_q |=> ext_data_en_q == $past(external_data_select)
      && expanded_data_ram_en_q == !$past(external_data_select))
    else $error("data move target wrong");
  chk_rom_rollover: assert property (@(posedge pclk) disable iff (!presetn)
    fetch_req && f_hi && boot_rom_enable_q |=> rom_en_q && fetch_source_q == FS_BOOT_ROM)
    else $error("fetch past code RAM missed boot ROM");
  chk_code_ram_fetch: assert property (@(posedge pclk) disable iff (!presetn)
    fetch_req && !f_hi |=> code_ram_en_q && !code_ram_we_q
      && code_ram_addr_q == $past(fetch_addr[14:0]))
    else $error("low fetch missed code RAM");
  chk_ext_strobe_seq: assert property (@(posedge pclk) disable iff (!presetn)
    ext_idle && fetch_req && f_hi && !boot_rom_enable_q && !lpc_q
      |=> !port0_oe_n_q && program_store_strobe_n_q ##1 !program_store_strobe_n_q
      ##4 ext_fetch_valid_q && program_store_strobe_n_q)
    else $error("external fetch sequence broken");
  chk_lpc_no_ext: assert property (@(posedge pclk) disable iff (!presetn)
    lpc_q |-> program_store_strobe_n_q && port0_oe_n_q)
    else $error("external access on low pin count part");
  chk_boot_vector: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(strap_done_q) |-> reset_vector_q == (ea_q ? 16'hf800 : 16'h0000))
    else $error("reset vector wrong");
  chk_boot_sel_frozen: assert property (@(posedge pclk) disable iff (!presetn)
    strap_done_q && $past(strap_done_q) |-> $stable(boot_from_nonvolatile_q))
    else $error("boot select changed after start");
endmodule : cmm_code_map

`default_nettype wire

// File: tb/cmm_core_model.sv
// Processor core model: issues fetches, program moves and data moves,
// and stands in for the external program memory on port 0.
// Assumes the bench calls its tasks from one process only.
`default_nettype none

module cmm_core_model (
  input wire logic pclk,
  input wire logic strobe_n,
  output logic fetch_req,
  output logic [15:0] fetch_addr,
  output logic pmove_req,
  output logic [15:0] pmove_addr,
  output logic xdata_req,
  output logic xdata_write,
  output logic [15:0] xdata_addr,
  output logic [7:0] xdata_wdata,
  output wire logic [7:0] port0_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] ext_byte;

  // ----------------------------------------
  // External memory drives its byte while strobed, the inverted byte otherwise
  // ----------------------------------------
  assign port0_in = strobe_n ? ~ext_byte : ext_byte;

  initial begin
    fetch_req = 1'b0;
    fetch_addr = 16'h0000;
    pmove_req = 1'b0;
    pmove_addr = 16'h0000;
    xdata_req = 1'b0;
    xdata_write = 1'b0;
    xdata_addr = 16'h0000;
    xdata_wdata = 8'h00;
    ext_byte = 8'h00;
  end

  // ----------------------------------------
  // One request per call; code kept clear of 7f00 area
  // ----------------------------------------
  task automatic fetch(input logic [15:0] a);
    @(posedge pclk);
    fetch_req <= 1'b1;
    fetch_addr <= a;
    @(posedge pclk);
    fetch_req <= 1'b0;
    fetch_addr <= ~a;
  endtask : fetch

  task automatic pmove(input logic [15:0] a);
    @(posedge pclk);
    pmove_req <= 1'b1;
    pmove_addr <= a;
    @(posedge pclk);
    pmove_req <= 1'b0;
    pmove_addr <= ~a;
  endtask : pmove

  // Data writes never share a cycle with a fetch
  task automatic xdata(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge pclk);
    xdata_req <= 1'b1;
    xdata_write <= w;
    xdata_addr <= a;
    xdata_wdata <= d;
    @(posedge pclk);
    xdata_req <= 1'b0;
    xdata_addr <= ~a;
    xdata_wdata <= ~d;
  endtask : xdata
endmodule : cmm_core_model

`default_nettype wire

// File: tb/cmm_code_map_tb.sv
// Self-checking bench for the code memory mapping block.
// Assumes the design files and the core model are compiled first.
`default_nettype none

module cmm_code_map_tb
  import cmm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata_q, rd;
  logic pready_q, pslverr_q, err;
  logic fetch_req, pmove_req, xdata_req, xdata_write;
  logic [15:0] fetch_addr, pmove_addr, xdata_addr;
  logic [7:0] xdata_wdata, port0_in;
  logic eds, ea_pin, boot_pin, lpc;
  cmm_fetch_src_type fetch_source_q;
  cmm_xdata_tgt_type xdata_target_q;
  logic rom_en_q, code_ram_en_q, code_ram_we_q, expanded_data_ram_en_q, ext_data_en_q, xdata_we_q;
  logic [14:0] rom_addr_q, code_ram_addr_q;
  logic [7:0] code_ram_wdata_q, port0_out_q, port2_out_q, ext_fetch_data_q;
  logic [15:0] xdata_addr_q, reset_vector_q;
  logic strobe_n_q, port0_oe_n_q, ext_fetch_valid_q, dps_q, nv_q, done_q;
  int error_cnt = 0;
  int samples_checked = 0;
  int cycles = 0;

  cmm_code_map #(.NV_LOAD_CYCLES(20)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q),
    .pslverr_q(pslverr_q), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
    .pmove_req(pmove_req), .pmove_addr(pmove_addr), .xdata_req(xdata_req),
    .xdata_write(xdata_write), .xdata_addr(xdata_addr), .xdata_wdata(xdata_wdata),
    .external_data_select(eds), .external_access_pin(ea_pin),
    .boot_select_pin(boot_pin), .low_pin_count_strap(lpc), .port0_in(port0_in),
    .fetch_source_q(fetch_source_q), .rom_en_q(rom_en_q), .rom_addr_q(rom_addr_q),
    .code_ram_en_q(code_ram_en_q), .code_ram_we_q(code_ram_we_q), .code_ram_addr_q(code_ram_addr_q),
    .code_ram_wdata_q(code_ram_wdata_q), .xdata_target_q(xdata_target_q), .expanded_data_ram_en_q(expanded_data_ram_en_q),
    .ext_data_en_q(ext_data_en_q), .xdata_we_q(xdata_we_q), .xdata_addr_q(xdata_addr_q),
    .program_store_strobe_n_q(strobe_n_q), .port0_out_q(port0_out_q),
    .port0_oe_n_q(port0_oe_n_q), .port2_out_q(port2_out_q),
    .ext_fetch_data_q(ext_fetch_data_q), .ext_fetch_valid_q(ext_fetch_valid_q),
    .data_pointer_select_q(dps_q), .reset_vector_q(reset_vector_q),
    .boot_from_nonvolatile_q(nv_q), .boot_load_done_q(done_q)
  );

  cmm_core_model u_core (
    .pclk(pclk), .strobe_n(strobe_n_q), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
    .pmove_req(pmove_req), .pmove_addr(pmove_addr), .xdata_req(xdata_req),
    .xdata_write(xdata_write), .xdata_addr(xdata_addr), .xdata_wdata(xdata_wdata),
    .port0_in(port0_in)
  );

  // ----------------------------------------
  // Clock, timeout and shared tasks
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      error_cnt++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic do_reset(input logic l);
    presetn <= 1'b0;
    lpc <= l;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask : do_reset

  // Request held until pready is seen high at an edge; a hang ends at the timeout
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready_q !== 1'b1);
    rd = prdata_q;
    err = pslverr_q;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_boot();
    chk(reset_vector_q, 32'hf800);
    chk(nv_q, 1);
    chk(done_q, 0);
    boot_pin <= 1'b0;
    repeat (30) @(posedge pclk);
    chk(done_q, 1);
    chk(nv_q, 1);
  endtask : t_boot

  task automatic t_regs();
    apb(0, 12'h288, 0);
    chk(rd, 32'h20);
    apb(0, 12'h344, 0);
    chk(rd, 32'h00);
    apb(1, 12'h288, 32'hff);
    apb(0, 12'h288, 0);
    chk(rd, 32'h29);
    chk(dps_q, 1);
    apb(1, 12'h288, 32'h20);
    #1 chk(dps_q, 0);
    apb(0, 12'h004, 0);
    chk({rd[30:0], err}, 1);
  endtask : t_regs

  task automatic t_fetch();
    u_core.fetch(16'h7eff);
    #1 chk({fetch_source_q, code_ram_en_q, code_ram_addr_q}, {FS_CODE_RAM, 1'b1, 15'h7eff});
    u_core.fetch(16'h8000);
    #1 chk({fetch_source_q, rom_en_q, rom_addr_q}, {FS_BOOT_ROM, 1'b1, 15'h0});
    u_core.fetch(16'hf800);
    #1 chk({rom_en_q, rom_addr_q}, {1'b1, 15'h7800});
    u_core.pmove(16'h0100);
    #1 chk({code_ram_en_q, code_ram_we_q, code_ram_addr_q}, {2'b10, 15'h100});
  endtask : t_fetch

  task automatic t_xdata();
    cmm_xdata_tgt_type t;
    for (int i = 0; i < 4; i++) begin
      apb(1, 12'h344, {28'h0, i[1], 3'h0});
      eds <= i[0];
      t = i[1] ? XT_CODE_RAM : (i[0] ? XT_EXTERNAL : XT_EXPANDED);
      u_core.xdata(i[0], 16'h1234, 8'h5a);
      #1 chk(xdata_target_q, t);
      chk({expanded_data_ram_en_q, ext_data_en_q, code_ram_we_q}, {t == XT_EXPANDED, t == XT_EXTERNAL,
          t == XT_CODE_RAM && i[0]});
      chk({xdata_we_q, xdata_addr_q}, {i[0], 16'h1234});
      if (i[1]) chk({code_ram_addr_q, code_ram_wdata_q}, {15'h1234, 8'h5a});
    end
    apb(1, 12'h344, 0);
    eds <= 1'b0;
  endtask : t_xdata

  task automatic t_ext();
    int n;
    n = 0;
    apb(1, 12'h288, 0);
    u_core.ext_byte <= 8'h3c;
    u_core.fetch(16'h9abc);
    #1 chk({port2_out_q, port0_out_q, port0_oe_n_q}, {16'h9abc, 1'b0});
    @(posedge pclk);
    #1 chk({strobe_n_q, port0_oe_n_q}, 2'b01);
    while (ext_fetch_valid_q !== 1'b1 && n < 10) begin
      @(posedge pclk);
      #1 n++;
    end
    chk({ext_fetch_data_q, fetch_source_q}, {8'h3c, FS_EXTERNAL});
    apb(1, 12'h288, 32'h20);
  endtask : t_ext

  task automatic t_lpc();
    ea_pin <= 1'b0;
    do_reset(1);
    chk(reset_vector_q, 32'h0000);
    apb(1, 12'h288, 0);
    u_core.fetch(16'h8000);
    #1 chk(fetch_source_q, FS_BLOCKED);
    repeat (6) begin
      @(posedge pclk);
      #1 chk(strobe_n_q, 1);
    end
    apb(0, 12'h100, 0);
    chk(rd, 32'h39);
    apb(1, 12'h100, 32'h20);
    apb(0, 12'h100, 0);
    chk(rd, 32'h19);
  endtask : t_lpc

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    eds = 1'b0;
    ea_pin = 1'b1;
    boot_pin = 1'b1;
    lpc = 1'b0;
    do_reset(0);
    t_boot();
    t_regs();
    t_fetch();
    t_xdata();
    t_ext();
    t_lpc();
    stop_test();
  end
endmodule : cmm_code_map_tb

`default_nettype wire
